// [scw_pkg.sv]
// Purpose: Shared constants and types for the command, address and write-data capture front end.
// Assumes: ref_clk is the command clock at 20 MHz; write_data_clock is the write-data clock pair.
// Notes:   All widths and timing counts used by both design files live here.

package scw_pkg;

  // ==========================================================================
  // Widths
  // ==========================================================================
  localparam int ADDR_W    = 23;
  localparam int BANK_W    = 3;
  localparam int NUM_BANKS = 8;
  localparam int DATA_W    = 18;
  localparam int LANE_W    = 9;
  localparam int BEATS     = 2;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int CLK_PERIOD_NS = 50;
  localparam int TRC_NS        = 20;
  localparam int TRC_CYC       = (TRC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BUSY_W        = 4;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [ADDR_W-1:0] MODE_CFG_RST = 23'h000000;
  localparam logic [1:0]        STROBE_RST   = 2'h0;
  localparam logic [1:0]        STROBE_INV_RST = 2'h3;
  localparam logic [1:0]        KEEP_NONE    = 2'h0;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [2:0] {
    CMD_NOP,
    CMD_READ,
    CMD_WRITE,
    CMD_REFRESH,
    CMD_MODE_SET
  } scw_cmd_e;

  typedef enum logic [0:0] {
    WR_IDLE,
    WR_WAIT
  } scw_wr_state_e;

endpackage

// [scw_wdata_capture.sv]
// Purpose: Captures one write burst (one beat per edge) of data and mask on the write-data clock pair.
// Assumes: write_data_clock_inv is the complement of write_data_clock and runs whenever the device is used.
// Notes:   The captured words stay stable until the next arm toggle, so the command side may read them.

`timescale 1ns/1ps

module scw_wdata_capture
  import scw_pkg::*;
#(
  parameter int DW = DATA_W
) (
  input  wire logic          write_data_clock,
  input  wire logic          write_data_clock_inv,
  input  wire logic          sys_rst,
  input  wire logic          arm_tgl,
  input  wire logic [DW-1:0] data_in,
  input  wire logic          write_beat_mask,
  output logic      [DW-1:0] beat_rise,
  output logic      [DW-1:0] beat_fall,
  output logic      [1:0]    beat_keep,
  output logic               done_tgl
);

  // ==========================================================================
  // Rising-edge side
  // ==========================================================================
  logic          arm_s1_q,  arm_s2_q,  arm_seen_q;
  logic          arm_seen_d;
  logic          pend_q,    pend_d;
  logic          done_q,    done_d;
  logic [DW-1:0] rise_q,    rise_d;
  logic          keep_r_q,  keep_r_d;
  logic          arm_evt;

  assign arm_evt = arm_s2_q ^ arm_seen_q;

  always_comb begin
    arm_seen_d = arm_seen_q;
    pend_d     = pend_q;
    done_d     = done_q;
    rise_d     = rise_q;
    keep_r_d   = keep_r_q;
    if (pend_q) begin
      pend_d = 1'b0;
      done_d = ~done_q;
    end else if (arm_evt) begin
      arm_seen_d = arm_s2_q;
      pend_d     = 1'b1;
      rise_d     = data_in;
      keep_r_d   = ~write_beat_mask;
    end
  end

  always_ff @(posedge write_data_clock or posedge sys_rst) begin
    if (sys_rst) begin
      arm_s1_q   <= 1'b0;
      arm_s2_q   <= 1'b0;
      arm_seen_q <= 1'b0;
      pend_q     <= 1'b0;
      done_q     <= 1'b0;
      rise_q     <= '0;
      keep_r_q   <= 1'b0;
    end else begin
      arm_s1_q   <= arm_tgl;
      arm_s2_q   <= arm_s1_q;
      arm_seen_q <= arm_seen_d;
      pend_q     <= pend_d;
      done_q     <= done_d;
      rise_q     <= rise_d;
      keep_r_q   <= keep_r_d;
    end
  end

  // ==========================================================================
  // Falling-edge side, clocked by the complement of the pair
  // ==========================================================================
  logic [DW-1:0] fall_q,   fall_d;
  logic          keep_f_q, keep_f_d;

  always_comb begin
    fall_d   = fall_q;
    keep_f_d = keep_f_q;
    if (pend_q) begin
      fall_d   = data_in;
      keep_f_d = ~write_beat_mask;
    end
  end

  always_ff @(posedge write_data_clock_inv or posedge sys_rst) begin
    if (sys_rst) begin
      fall_q   <= '0;
      keep_f_q <= 1'b0;
    end else begin
      fall_q   <= fall_d;
      keep_f_q <= keep_f_d;
    end
  end

  assign beat_rise = rise_q;
  assign beat_fall = fall_q;
  assign beat_keep = {keep_f_q, keep_r_q};
  assign done_tgl  = done_q;

endmodule // scw_wdata_capture

// [scw_front_end.sv]
// Purpose: Command, bank and address capture with write-data handover for a separate-I/O DDR memory.
// Assumes: Command pins change with ref_clk; write data arrives on its own clock pair.
// Notes:   There is no reset pin on the part; sys_rst stands in for power-up initialisation.

`timescale 1ns/1ps

module scw_front_end
  import scw_pkg::*;
#(
  parameter int AW   = ADDR_W,
  parameter int BW   = BANK_W,
  parameter int NB   = NUM_BANKS,
  parameter int DW   = DATA_W,
  parameter int BUSY = TRC_CYC
) (
  input  wire logic          ref_clk,
  input  wire logic          sys_rst,
  input  wire logic          chip_sel_n,
  input  wire logic          write_en_n,
  input  wire logic          refresh_n,
  input  wire logic [BW-1:0] bank_sel,
  input  wire logic [AW-1:0] addr,
  input  wire logic          write_data_clock,
  input  wire logic          write_data_clock_inv,
  input  wire logic [DW-1:0] data_in,
  input  wire logic          write_beat_mask,
  input  wire logic [DW-1:0] core_rd_data,
  input  wire logic          core_rd_valid,
  output logic               cmd_valid,
  output logic      [2:0]    cmd_kind,
  output logic      [BW-1:0] cmd_bank,
  output logic      [AW-1:0] cmd_addr,
  output logic      [AW-1:0] mode_cfg,
  output logic      [NB-1:0] bank_busy,
  output logic               bank_conflict,
  output logic               wr_valid,
  output logic      [BW-1:0] wr_bank,
  output logic      [AW-1:0] wr_addr,
  output logic      [DW-1:0] wr_data_rise,
  output logic      [DW-1:0] wr_data_fall,
  output logic      [1:0]    wr_beat_keep,
  output logic               wr_dropped,
  output logic      [1:0]    read_data_strobe,
  output logic      [1:0]    read_data_strobe_inv,
  output logic      [DW-1:0] read_out,
  output logic               read_valid_flag
);

  // ==========================================================================
  // Pin capture: two rising-edge stages, all pins moving together
  // ==========================================================================
  logic          cs_s1_q,   cs_s2_q;
  logic          we_s1_q,   we_s2_q;
  logic          rf_s1_q,   rf_s2_q;
  logic [BW-1:0] ba_s1_q,   ba_s2_q;
  logic [AW-1:0] ad_s1_q,   ad_s2_q;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
      we_s1_q <= 1'b1;
      we_s2_q <= 1'b1;
      rf_s1_q <= 1'b1;
      rf_s2_q <= 1'b1;
      ba_s1_q <= '0;
      ba_s2_q <= '0;
      ad_s1_q <= '0;
      ad_s2_q <= '0;
    end else begin
      cs_s1_q <= chip_sel_n;
      cs_s2_q <= cs_s1_q;
      we_s1_q <= write_en_n;
      we_s2_q <= we_s1_q;
      rf_s1_q <= refresh_n;
      rf_s2_q <= rf_s1_q;
      ba_s1_q <= bank_sel;
      ba_s2_q <= ba_s1_q;
      ad_s1_q <= addr;
      ad_s2_q <= ad_s1_q;
    end
  end

  // ==========================================================================
  // Command decoder
  // ==========================================================================
  scw_cmd_e cmd_dec;

  always_comb begin
    cmd_dec = CMD_NOP;
    if (!cs_s2_q) begin
      case ({we_s2_q, rf_s2_q})
        2'h0:    cmd_dec = CMD_MODE_SET;
        2'h1:    cmd_dec = CMD_WRITE;
        2'h2:    cmd_dec = CMD_REFRESH;
        2'h3:    cmd_dec = CMD_READ;
        default: cmd_dec = CMD_NOP;
      endcase
    end
  end

  logic          cmd_valid_q, cmd_valid_d;
  logic [2:0]    cmd_kind_q,  cmd_kind_d;
  logic [BW-1:0] cmd_bank_q,  cmd_bank_d;
  logic [AW-1:0] cmd_addr_q,  cmd_addr_d;
  logic [AW-1:0] mode_cfg_q,  mode_cfg_d;
  logic          conflict_q,  conflict_d;
  logic [NB-1:0] busy_now;
  logic          bank_cmd;

  assign bank_cmd = (cmd_dec == CMD_READ) || (cmd_dec == CMD_WRITE) || (cmd_dec == CMD_REFRESH);

  always_comb begin
    cmd_valid_d = 1'b0;
    cmd_kind_d  = CMD_NOP;
    cmd_bank_d  = cmd_bank_q;
    cmd_addr_d  = cmd_addr_q;
    mode_cfg_d  = mode_cfg_q;
    conflict_d  = 1'b0;
    if (cmd_dec == CMD_MODE_SET) begin
      mode_cfg_d = ad_s2_q;
    end else if (bank_cmd) begin
      cmd_valid_d = 1'b1;
      cmd_kind_d  = cmd_dec;
      cmd_bank_d  = ba_s2_q;
      cmd_addr_d  = ad_s2_q;
      conflict_d  = busy_now[ba_s2_q];
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cmd_valid_q <= 1'b0;
      cmd_kind_q  <= CMD_NOP;
      cmd_bank_q  <= '0;
      cmd_addr_q  <= '0;
      mode_cfg_q  <= MODE_CFG_RST;
      conflict_q  <= 1'b0;
    end else begin
      cmd_valid_q <= cmd_valid_d;
      cmd_kind_q  <= cmd_kind_d;
      cmd_bank_q  <= cmd_bank_d;
      cmd_addr_q  <= cmd_addr_d;
      mode_cfg_q  <= mode_cfg_d;
      conflict_q  <= conflict_d;
    end
  end

  // ==========================================================================
  // Per-bank cycle timers; they keep counting whatever chip select does
  // ==========================================================================
  localparam logic [BUSY_W-1:0] BUSY_LOAD = BUSY_W'(BUSY);

  logic [NB-1:0] busy_q;

  for (genvar b = 0; b < NB; b++) begin : g_bank
    logic [BUSY_W-1:0] cnt_q, cnt_d;

    always_comb begin
      cnt_d = cnt_q;
      if (bank_cmd && (ba_s2_q == BW'(b))) begin
        cnt_d = BUSY_LOAD;
      end else if (cnt_q != '0) begin
        cnt_d = cnt_q - 1'b1;
      end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
        cnt_q     <= '0;
        busy_q[b] <= 1'b0;
      end else begin
        cnt_q     <= cnt_d;
        busy_q[b] <= (cnt_d != '0);
      end
    end

    assign busy_now[b] = (cnt_q != '0);
  end

  // ==========================================================================
  // Write handover between the command side and the write-data clock pair
  // ==========================================================================
  logic [DW-1:0] cap_rise, cap_fall;
  logic [1:0]    cap_keep;
  logic          cap_done_tgl;
  logic          arm_tgl_q,  arm_tgl_d;

  scw_wdata_capture #(
    .DW (DW)
  ) u_wdata (
    .write_data_clock     (write_data_clock),
    .write_data_clock_inv (write_data_clock_inv),
    .sys_rst              (sys_rst),
    .arm_tgl              (arm_tgl_q),
    .data_in              (data_in),
    .write_beat_mask      (write_beat_mask),
    .beat_rise            (cap_rise),
    .beat_fall            (cap_fall),
    .beat_keep            (cap_keep),
    .done_tgl             (cap_done_tgl)
  );

  scw_wr_state_e wr_st_q, wr_st_d;
  logic          dn_s1_q,    dn_s2_q,    dn_seen_q, dn_seen_d;
  logic          wr_valid_q, wr_valid_d;
  logic [BW-1:0] wr_bank_q,  wr_bank_d;
  logic [AW-1:0] wr_addr_q,  wr_addr_d;
  logic [DW-1:0] wr_rise_q,  wr_rise_d;
  logic [DW-1:0] wr_fall_q,  wr_fall_d;
  logic [1:0]    wr_keep_q,  wr_keep_d;
  logic          wr_drop_q,  wr_drop_d;

  always_comb begin
    wr_st_d    = wr_st_q;
    arm_tgl_d  = arm_tgl_q;
    dn_seen_d  = dn_seen_q;
    wr_valid_d = 1'b0;
    wr_bank_d  = wr_bank_q;
    wr_addr_d  = wr_addr_q;
    wr_rise_d  = wr_rise_q;
    wr_fall_d  = wr_fall_q;
    wr_keep_d  = KEEP_NONE;
    wr_drop_d  = 1'b0;
    case (wr_st_q)
      WR_IDLE: begin
        if (cmd_dec == CMD_WRITE) begin
          arm_tgl_d = ~arm_tgl_q;
          wr_bank_d = ba_s2_q;
          wr_addr_d = ad_s2_q;
          wr_st_d   = WR_WAIT;
        end
      end
      WR_WAIT: begin
        wr_drop_d = (cmd_dec == CMD_WRITE);
        if (dn_s2_q != dn_seen_q) begin
          dn_seen_d  = dn_s2_q;
          wr_valid_d = 1'b1;
          wr_rise_d  = cap_rise;
          wr_fall_d  = cap_fall;
          wr_keep_d  = cap_keep;
          wr_st_d    = WR_IDLE;
        end
      end
      default: wr_st_d = WR_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_st_q    <= WR_IDLE;
      arm_tgl_q  <= 1'b0;
      dn_s1_q    <= 1'b0;
      dn_s2_q    <= 1'b0;
      dn_seen_q  <= 1'b0;
      wr_valid_q <= 1'b0;
      wr_bank_q  <= '0;
      wr_addr_q  <= '0;
      wr_rise_q  <= '0;
      wr_fall_q  <= '0;
      wr_keep_q  <= KEEP_NONE;
      wr_drop_q  <= 1'b0;
    end else begin
      wr_st_q    <= wr_st_d;
      arm_tgl_q  <= arm_tgl_d;
      dn_s1_q    <= cap_done_tgl;
      dn_s2_q    <= dn_s1_q;
      dn_seen_q  <= dn_seen_d;
      wr_valid_q <= wr_valid_d;
      wr_bank_q  <= wr_bank_d;
      wr_addr_q  <= wr_addr_d;
      wr_rise_q  <= wr_rise_d;
      wr_fall_q  <= wr_fall_d;
      wr_keep_q  <= wr_keep_d;
      wr_drop_q  <= wr_drop_d;
    end
  end

  // ==========================================================================
  // Read return: free-running strobes, data and valid change on strobe edges
  // ==========================================================================
  logic [1:0]    strobe_q,     strobe_d;
  logic [1:0]    strobe_inv_q;
  logic [DW-1:0] rd_out_q,     rd_out_d;
  logic          rd_valid_q,   rd_valid_d;

  always_comb begin
    strobe_d   = ~strobe_q;
    rd_valid_d = core_rd_valid;
    rd_out_d   = core_rd_valid ? core_rd_data : rd_out_q;
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      strobe_q     <= STROBE_RST;
      strobe_inv_q <= STROBE_INV_RST;
      rd_out_q     <= '0;
      rd_valid_q   <= 1'b0;
    end else begin
      strobe_q     <= strobe_d;
      strobe_inv_q <= ~strobe_d;
      rd_out_q     <= rd_out_d;
      rd_valid_q   <= rd_valid_d;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign cmd_valid            = cmd_valid_q;
  assign cmd_kind             = cmd_kind_q;
  assign cmd_bank             = cmd_bank_q;
  assign cmd_addr             = cmd_addr_q;
  assign mode_cfg             = mode_cfg_q;
  assign bank_busy            = busy_q;
  assign bank_conflict        = conflict_q;
  assign wr_valid             = wr_valid_q;
  assign wr_bank              = wr_bank_q;
  assign wr_addr              = wr_addr_q;
  assign wr_data_rise         = wr_rise_q;
  assign wr_data_fall         = wr_fall_q;
  assign wr_beat_keep         = wr_keep_q;
  assign wr_dropped           = wr_drop_q;
  assign read_data_strobe     = strobe_q;
  assign read_data_strobe_inv = strobe_inv_q;
  assign read_out             = rd_out_q;
  assign read_valid_flag      = rd_valid_q;

endmodule // scw_front_end

// [scw_fe_assertions.sv]
// Purpose: Concurrent checks on the ports of the command and write-data capture front end.
// Assumes: All checks run in the ref_clk domain; sys_rst is asynchronous and active high.
// Notes:   Bound to every scw_front_end instance by the bind after the module.

`timescale 1ns/1ps

module scw_fe_assertions
  import scw_pkg::*;
#(
  parameter int AW = ADDR_W,
  parameter int BW = BANK_W,
  parameter int NB = NUM_BANKS,
  parameter int DW = DATA_W
) (
  input wire logic          ref_clk,
  input wire logic          sys_rst,
  input wire logic          chip_sel_n,
  input wire logic          write_en_n,
  input wire logic          refresh_n,
  input wire logic [BW-1:0] bank_sel,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] core_rd_data,
  input wire logic          core_rd_valid,
  input wire logic          cmd_valid,
  input wire logic [2:0]    cmd_kind,
  input wire logic [BW-1:0] cmd_bank,
  input wire logic [AW-1:0] cmd_addr,
  input wire logic [AW-1:0] mode_cfg,
  input wire logic [NB-1:0] bank_busy,
  input wire logic          wr_valid,
  input wire logic [1:0]    wr_beat_keep,
  input wire logic          wr_dropped,
  input wire logic [1:0]    read_data_strobe,
  input wire logic [1:0]    read_data_strobe_inv,
  input wire logic [DW-1:0] read_out,
  input wire logic          read_valid_flag
);
  // ======
  // Decoded pin states
  // ======
  wire logic is_rd = !chip_sel_n && write_en_n && refresh_n;
  wire logic is_rf = !chip_sel_n && write_en_n && !refresh_n;
  wire logic is_wr = !chip_sel_n && !write_en_n && refresh_n;
  wire logic is_ms = !chip_sel_n && !write_en_n && !refresh_n;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  // ======
  // Assertions
  // ======
  a_read_decode: assert property (is_rd |-> ##3 cmd_valid && cmd_kind == 3'(CMD_READ))
    else $error("read command not decoded");
  a_refresh_decode: assert property (is_rf |-> ##3 cmd_valid && cmd_kind == 3'(CMD_REFRESH))
    else $error("refresh command not decoded");
  a_cs_ignore: assert property (chip_sel_n |-> ##3 !cmd_valid)
    else $error("command decoded while deselected");
  a_addr_capture: assert property ((is_rd || is_rf) |-> ##3 cmd_addr == $past(addr, 3) && cmd_bank == $past(bank_sel, 3))
    else $error("bank or address not taken whole");
  a_mode_load: assert property (is_ms |-> ##3 mode_cfg == $past(addr, 3))
    else $error("mode settings not loaded");
  a_mode_hold: assert property (!$stable(mode_cfg) |-> $past(is_ms, 3))
    else $error("mode settings changed without mode set");
  a_busy_target: assert property (cmd_valid |-> bank_busy[cmd_bank])
    else $error("target bank not busy");
  a_strobe_pair: assert property (read_data_strobe_inv == ~read_data_strobe)
    else $error("strobe pair not complementary");
  a_strobe_run: assert property (!$past(sys_rst) |-> read_data_strobe == ~$past(read_data_strobe))
    else $error("read strobe not toggling");
  a_valid_follow: assert property (core_rd_valid |=> read_valid_flag && read_out == $past(core_rd_data))
    else $error("read valid or data missing");
  a_valid_quiet: assert property (!core_rd_valid |=> !read_valid_flag)
    else $error("read valid without data");
  a_keep_only: assert property (wr_beat_keep != 2'h0 |-> wr_valid)
    else $error("beat keep outside a burst");
  a_write_done: assert property (is_wr |-> ##[4:30] wr_valid)
    else $error("write burst not delivered");

  c_write_full: cover property (wr_valid && wr_beat_keep == 2'h3);
  c_write_masked: cover property (wr_valid && wr_beat_keep == 2'h0);
  c_write_dropped: cover property (wr_dropped);
  c_read_valid: cover property (read_valid_flag);
endmodule // scw_fe_assertions

bind scw_front_end scw_fe_assertions #(.AW(AW), .BW(BW), .NB(NB), .DW(DW)) u_chk (
  .ref_clk, .sys_rst, .chip_sel_n, .write_en_n, .refresh_n, .bank_sel, .addr, .core_rd_data,
  .core_rd_valid, .cmd_valid, .cmd_kind, .cmd_bank, .cmd_addr, .mode_cfg, .bank_busy, .wr_valid,
  .wr_beat_keep, .wr_dropped, .read_data_strobe, .read_data_strobe_inv, .read_out, .read_valid_flag
);

// [scw_ctrl_model.sv]
// Purpose: Memory controller model driving command pins and write data.
// Assumes: Pins change just after a ref_clk rise; the data clock runs free at 80 ns.
// Notes:   Apart from chip_sel_n, which returns high, deselected or released lines show the inverse of their last value.

`timescale 1ns/1ps

module scw_ctrl_model
  import scw_pkg::*;
(
  input  wire logic              ref_clk,
  output logic                   chip_sel_n,
  output logic                   write_en_n,
  output logic                   refresh_n,
  output logic      [BANK_W-1:0] bank_sel,
  output logic      [ADDR_W-1:0] addr,
  output logic                   write_data_clock,
  output logic                   write_data_clock_inv,
  output logic      [DATA_W-1:0] data_in,
  output logic                   write_beat_mask
);
  initial begin
    {chip_sel_n, write_en_n, refresh_n} = 3'h7;
    bank_sel = 3'h0;
    addr = 23'h000000;
    data_in = 18'h00000;
    write_beat_mask = 1'b0;
    write_data_clock = 1'b0;
    #13;
    forever #40 write_data_clock = ~write_data_clock;
  end

  assign write_data_clock_inv = ~write_data_clock;

  // One command cycle; write data is held until release_data.
  task automatic issue(input logic cs_n, input logic we_n, input logic rf_n, input logic [BANK_W-1:0] b,
                       input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic m);
    @(posedge ref_clk);
    chip_sel_n <= cs_n;
    write_en_n <= we_n;
    refresh_n <= rf_n;
    bank_sel <= b;
    addr <= a;
    if (!we_n) begin
      data_in <= d;
      write_beat_mask <= m;
    end
    @(posedge ref_clk);
    chip_sel_n <= 1'b1;
    write_en_n <= ~we_n;
    refresh_n <= ~rf_n;
    bank_sel <= ~b;
    addr <= ~a;
  endtask

  task automatic release_data;
    @(posedge ref_clk);
    data_in <= ~data_in;
    write_beat_mask <= ~write_beat_mask;
  endtask
endmodule // scw_ctrl_model

// [tb_sdram_cmd_addr_wdata_capture.sv]
// Purpose: Self-checking bench for the command and write-data capture front end.
// Assumes: ref_clk 50 ns, data clock 80 ns from the controller model.
// Notes:   Each scenario is one task that drives and judges its own results.

`timescale 1ns/1ps

module tb_sdram_cmd_addr_wdata_capture;
  import scw_pkg::*;
  logic                  ref_clk, sys_rst, chip_sel_n, write_en_n, refresh_n, core_rd_valid;
  logic                  write_data_clock, write_data_clock_inv, write_beat_mask, cmd_valid;
  logic                  bank_conflict, wr_valid, wr_dropped, read_valid_flag;
  logic [2:0]            cmd_kind, cmd_bank, bank_sel, wr_bank;
  logic [ADDR_W-1:0]     addr, cmd_addr, mode_cfg, wr_addr;
  logic [DATA_W-1:0]     data_in, core_rd_data, wr_data_rise, wr_data_fall, read_out;
  logic [NUM_BANKS-1:0]  bank_busy;
  logic [1:0]            wr_beat_keep, read_data_strobe, read_data_strobe_inv;
  int                    mismatches = 0;
  int                    total_checks = 0;

  scw_front_end uut (.ref_clk, .sys_rst, .chip_sel_n, .write_en_n, .refresh_n, .bank_sel, .addr,
    .write_data_clock, .write_data_clock_inv, .data_in, .write_beat_mask, .core_rd_data, .core_rd_valid,
    .cmd_valid, .cmd_kind, .cmd_bank, .cmd_addr, .mode_cfg, .bank_busy, .bank_conflict, .wr_valid, .wr_bank,
    .wr_addr, .wr_data_rise, .wr_data_fall, .wr_beat_keep, .wr_dropped, .read_data_strobe,
    .read_data_strobe_inv, .read_out, .read_valid_flag);

  scw_ctrl_model ctl (.ref_clk, .chip_sel_n, .write_en_n, .refresh_n, .bank_sel, .addr,
    .write_data_clock, .write_data_clock_inv, .data_in, .write_beat_mask);

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // ======
  // Shared helpers
  // ======
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ======
  // Scenarios
  // ======
  task automatic t_read_banks;
    logic [ADDR_W-1:0] a;
    for (int i = 0; i < NUM_BANKS; i++) begin
      a = {3'(i), 20'hA5C3F} ^ {ADDR_W{i[0]}};
      ctl.issue(1'b0, 1'b1, 1'b1, 3'(i), a, 18'h00000, 1'b0);
      settle(2);
      chk(cmd_valid, 1);
      chk(bank_conflict, 0);
      chk(cmd_kind, CMD_READ);
      chk(cmd_bank, i);
      chk(cmd_addr, a);
      chk(bank_busy, 32'h1 << i);
    end
    $display("t_read_banks done");
  endtask

  task automatic t_refresh_mode;
    ctl.issue(1'b0, 1'b1, 1'b0, 3'h6, 23'h2AAAAA, 18'h00000, 1'b0);
    settle(2);
    chk(cmd_kind, CMD_REFRESH);
    chk(cmd_bank, 3'h6);
    ctl.issue(1'b0, 1'b0, 1'b0, 3'h1, 23'h5A5A5A, 18'h00000, 1'b0);
    settle(3);
    chk(mode_cfg, 23'h5A5A5A);
    $display("t_refresh_mode done");
  endtask

  task automatic t_cs_high;
    ctl.issue(1'b1, 1'b0, 1'b0, 3'h2, 23'h0F0F0F, 18'h00000, 1'b0);
    settle(2);
    chk(cmd_valid, 0);
    chk(mode_cfg, 23'h5A5A5A);
    ctl.issue(1'b1, 1'b1, 1'b1, 3'h3, 23'h123456, 18'h00000, 1'b0);
    settle(2);
    chk(cmd_valid, 0);
    $display("t_cs_high done");
  endtask

  task automatic t_write_mask;
    logic [DATA_W-1:0] d;
    int n;
    for (int m = 0; m < 2; m++) begin
      d = 18'h25A5A ^ {DATA_W{m[0]}};
      ctl.issue(1'b0, 1'b0, 1'b1, 3'(7 - m), 23'h400000 + 23'(m), d, m[0]);
      for (n = 0; n < 40 && wr_valid !== 1'b1; n++) settle(1);
      chk(wr_valid, 1);
      chk(wr_addr, 23'h400000 + 23'(m));
      chk(wr_bank, 7 - m);
      chk(wr_beat_keep, m ? 2'h0 : 2'h3);
      if (m == 0) begin
        chk(wr_data_rise, d);
        chk(wr_data_fall, d);
      end
      ctl.release_data();
    end
    $display("t_write_mask done");
  endtask

  task automatic t_write_drop;
    int seen;
    int drop;
    logic [ADDR_W-1:0] got;
    seen = 0;
    drop = 0;
    got = '0;
    ctl.issue(1'b0, 1'b0, 1'b1, 3'h1, 23'h111111, 18'h12345, 1'b0);
    ctl.issue(1'b0, 1'b0, 1'b1, 3'h2, 23'h222222, 18'h12345, 1'b0);
    repeat (40) begin
      settle(1);
      if (wr_valid === 1'b1) begin
        seen++;
        got = wr_addr;
      end
      if (wr_dropped === 1'b1) drop++;
    end
    chk(seen, 1);
    chk(drop, 1);
    chk(got, 23'h111111);
    ctl.release_data();
    $display("t_write_drop done");
  endtask

  task automatic t_read_path;
    logic [1:0] s;
    @(posedge ref_clk);
    core_rd_valid <= 1'b1;
    core_rd_data <= 18'h2C3A5;
    @(posedge ref_clk);
    core_rd_data <= 18'h1D2E3;
    #1;
    chk(read_valid_flag, 1);
    chk(read_out, 18'h2C3A5);
    s = read_data_strobe;
    @(posedge ref_clk);
    core_rd_valid <= 1'b0;
    #1;
    chk(read_out, 18'h1D2E3);
    chk(read_data_strobe, {~s});
    chk(read_data_strobe_inv, s);
    settle(1);
    chk(read_valid_flag, 0);
    $display("t_read_path done");
  endtask

  // ======
  // Main sequence and watchdog
  // ======
  initial begin
    sys_rst = 1'b1;
    core_rd_valid = 1'b0;
    core_rd_data = 18'h00000;
    settle(2);
    chk(mode_cfg, MODE_CFG_RST);
    chk(read_data_strobe_inv, STROBE_INV_RST);
    @(posedge ref_clk);
    sys_rst <= 1'b0;
    t_read_banks();
    t_refresh_mode();
    t_cs_high();
    t_write_mask();
    t_write_drop();
    t_read_path();
    final_report();
  end

  initial begin
    #100000;
    mismatches++;
    final_report();
  end
endmodule // tb_sdram_cmd_addr_wdata_capture
